// ### logic/meg_consts.vh
// Purpose : constants for the multi-stage envelope generator
// Assumes : APB byte addresses, 32-bit data
// Notes   : offsets, fields, reset values and timing counts
`ifndef MEG_CONSTS_VH
`define MEG_CONSTS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define MEG_OFS_TIME0  8'h00
`define MEG_OFS_TIME1  8'h04
`define MEG_OFS_MODE   8'h08
`define MEG_OFS_STAT   8'h0C
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define MEG_RST_TIME0  32'h6300_0000
`define MEG_RST_TIME1  32'h0063_0063
`define MEG_RST_MODE   32'h0000_0000
// ---------------------------------------------------------------
// mode register fields
// ---------------------------------------------------------------
`define MEG_MODE_RESTART 0
`define MEG_MODE_FREERUN 1
`define MEG_MODE_TRACK   2
`define MEG_MODE_PEDAL   3
`define MEG_MODE_MONO    4
`define MEG_MODE_FILT    5
`define MEG_MODE_MATSRC  6
// ---------------------------------------------------------------
// setting values and levels
// ---------------------------------------------------------------
`define MEG_SET_MAX    7'd99
`define MEG_LVL_MAX    16'hFFFF
`define MEG_LVL_STEP   16'h0100
`define MEG_SUS_MUL    10'd662
`define MEG_KEY_MID    7'd60
// ---------------------------------------------------------------
// timing: cycles per step = setting squared shifted left by this
// ---------------------------------------------------------------
`define MEG_TIME_SHIFT 9
`define MEG_TIME_FULL  5'd23
`endif

// ### logic/meg_envelope.v
// Purpose : per-voice envelope generator with delay, attack,
//           decay, sustain decay and release stages, APB slave
// Assumes : note events synchronous to CORE_CLK, 250 MHz
// Notes   : one tick period per 256th of full scale per stage
//
// Overview of operation
// RULE1 - delay zero starts attack at once on note start
// RULE2 - delay above 99 holds until key release, then attacks
// RULE3 - hold delay forces run-to-completion behaviour
// RULE4 - sustain decays to zero; 99 holds, 0 drops at once
// RULE5 - attack ramps to maximum; zero is an abrupt edge
// RULE6 - decay heads for sustain level; sustain 99 skips decay
// RULE7 - note or pedal release enters release, ramps to zero
// RULE8 - normal mode: new note does not restart the envelope
// RULE9 - normal mode: note release goes straight to release
// RULE10 - run-to-completion finishes the cycle despite release
// RULE11 - restart mode: each new note restarts from first stage
// RULE12 - four trigger modes from restart and complete bits
// RULE13 - mono legato retriggers only with restart set
// RULE14 - key tracking scales later stage times two per two octaves
// RULE15 - key tracking never touches the attack time
// RULE16 - pedal short-envelope case jumps to release on note off
// RULE17 - pedal held, released in attack: go to sustain decay
// RULE18 - pedal held, released in delay: output stays zero
// RULE19 - same case with completion: run on, stay in sustain
// RULE20 - pedal response off: pedal is ignored
// RULE21 - level setting scales output, 00 none, 99 full
// RULE22 - velocity modulation scales output by note velocity
// RULE23 - filter instance acts only with depth or matrix source
// RULE24 - time settings map monotonically onto stage durations
// RULE25 - event source gives synchronous strobes and levels
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`include "meg_consts.vh"

module meg_envelope (
  // clock and reset
  input  wire        CORE_CLK,
  input  wire        RSTN,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // note events
  input  wire        NOTE_ON,
  input  wire        NOTE_OFF,
  input  wire [6:0]  NOTE_KEY,
  input  wire [6:0]  NOTE_VEL,
  input  wire        PEDAL,
  // envelope output
  output reg  [15:0] ENV_OUT,
  output reg  [2:0]  ENV_STAGE,
  output reg         ENV_ACTIVE
);

  // ---------------------------------------------------------------
  // stage codes
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DLY  = 3'd1;
  localparam [2:0] ST_ATK  = 3'd2;
  localparam [2:0] ST_DEC  = 3'd3;
  localparam [2:0] ST_SUS  = 3'd4;
  localparam [2:0] ST_REL  = 3'd5;

  reg [31:0] time0_q, time1_q, mode_q;
  reg [2:0]  stage_q, stage_d;
  reg [15:0] env_q, env_d;
  reg [33:0] cnt_q, cnt_d;
  reg        key_q, sus_q, relp_q;
  reg        sus_d, relp_d;
  reg [6:0]  trk_key_q, vel_q;

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  wire [6:0] s_dly  = time0_q[6:0];
  wire [6:0] s_atk  = time0_q[14:8];
  wire [6:0] s_dec  = time0_q[22:16];
  wire [6:0] s_sus  = time0_q[30:24];
  wire [6:0] s_sdc  = time1_q[6:0];
  wire [6:0] s_rel  = time1_q[14:8];
  wire [6:0] s_lvl  = time1_q[22:16];
  wire [6:0] s_vmod = time1_q[30:24];
  wire [6:0] s_dep  = mode_q[14:8];
  wire hold     = (s_dly > `MEG_SET_MAX);                  // RULE2
  wire restart  = mode_q[`MEG_MODE_RESTART];               // RULE12
  wire freerun  = mode_q[`MEG_MODE_FREERUN] | hold;        // RULE3
  wire pedal_on = mode_q[`MEG_MODE_PEDAL];
  wire ped_held = pedal_on & PEDAL;                        // RULE20
  wire [16:0] sus_prod = s_sus * `MEG_SUS_MUL;
  wire [15:0] sus_lvl  = (s_sus >= `MEG_SET_MAX) ?
                         `MEG_LVL_MAX : sus_prod[15:0];

  // ---------------------------------------------------------------
  // setting to cycles per step, squared curve
  // ---------------------------------------------------------------
  function [33:0] meg_period;                              // RULE24
    input [6:0] s;
    reg   [13:0] sq;
    begin
      sq = s * s;
      meg_period = {11'd0, sq, 9'd0} >> (9 - `MEG_TIME_SHIFT);
    end
  endfunction

  // key tracking: factor two per 24 keys around the middle key
  function [33:0] meg_track;                               // RULE14
    input [33:0] p;
    input [6:0]  key;
    reg   [7:0]  du;
    reg   [2:0]  whole;
    reg   [4:0]  r;
    reg   [10:0] fr;
    reg   [6:0]  fac;
    reg   [44:0] prod;
    begin
      // lower keys give larger du and so longer periods
      if (key >= `MEG_KEY_MID + 7'd48)
        du = 8'd0;
      else if ({1'b0, key} + 8'd48 <= {1'b0, `MEG_KEY_MID})
        du = 8'd96;
      else
        du = 8'd108 - {1'b0, key};
      whole = (du >= 8'd96) ? 3'd4 : (du >= 8'd72) ? 3'd3 :
              (du >= 8'd48) ? 3'd2 : (du >= 8'd24) ? 3'd1 : 3'd0;
      // five-bit wrap is harmless: the remainder is always below 24
      r    = du[4:0] - whole * 5'd24;
      fr   = r * 6'd43;
      fac  = 7'd32 + {1'b0, fr[10:5]};
      prod = (p * fac) << whole;
      meg_track = prod[40:7];
    end
  endfunction

  wire track = mode_q[`MEG_MODE_TRACK];
  reg  [33:0] per;
  // period of the running stage; attack and delay never tracked
  always @* begin
    case (stage_q)
      ST_DLY:  per = meg_period(s_dly);
      ST_ATK:  per = meg_period(s_atk);                    // RULE15
      ST_DEC:  per = track ? meg_track(meg_period(s_dec), trk_key_q)
                           : meg_period(s_dec);
      ST_SUS:  per = track ? meg_track(meg_period(s_sdc), trk_key_q)
                           : meg_period(s_sdc);
      ST_REL:  per = track ? meg_track(meg_period(s_rel), trk_key_q)
                           : meg_period(s_rel);
      default: per = 34'd1;
    endcase
  end
  wire tick = (cnt_q + 34'd1 >= per);

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  // pedal lift after a pedal-held note off counts as release
  wire ped_rel = sus_q & ~key_q & pedal_on & ~PEDAL;       // RULE7
  wire short_env = (s_dly == 7'd0) & (s_atk == 7'd0) &
                   ((s_dec == 7'd0) | (s_sus >= `MEG_SET_MAX));
  wire legato = key_q & mode_q[`MEG_MODE_MONO];
  wire retrig = restart;                                   // RULE13
  wire [2:0] first_st = (s_dly == 7'd0) ? ST_ATK : ST_DLY; // RULE1

  // ---------------------------------------------------------------
  // stage machine
  // ---------------------------------------------------------------
  always @* begin
    stage_d = stage_q;
    env_d   = env_q;
    cnt_d   = tick ? 34'd0 : cnt_q + 34'd1;
    sus_d   = sus_q;
    relp_d  = relp_q;
    // stage progression
    case (stage_q)
      ST_DLY: begin
        if (!hold && tick) begin
          stage_d = ST_ATK;
          cnt_d   = 34'd0;
        end
      end
      ST_ATK: begin
        if (s_atk == 7'd0 || (tick &&
            env_q >= `MEG_LVL_MAX - `MEG_LVL_STEP)) begin  // RULE5
          env_d   = `MEG_LVL_MAX;
          stage_d = (s_sus >= `MEG_SET_MAX) ? ST_SUS : ST_DEC; // RULE6
          cnt_d   = 34'd0;
        end else if (tick)
          env_d = env_q + `MEG_LVL_STEP;
      end
      ST_DEC: begin
        if (s_dec == 7'd0 || env_q <= sus_lvl ||
            (tick && env_q - `MEG_LVL_STEP <= sus_lvl)) begin // RULE6
          env_d   = sus_lvl;
          stage_d = ST_SUS;
          cnt_d   = 34'd0;
        end else if (tick)
          env_d = env_q - `MEG_LVL_STEP;
      end
      ST_SUS: begin
        if (relp_q) begin                                  // RULE10
          stage_d = ST_REL;
          relp_d  = 1'b0;
          cnt_d   = 34'd0;
        end else if (s_sdc == 7'd0)
          env_d = 16'h0000;                                // RULE4
        else if (s_sdc < `MEG_SET_MAX && tick)
          env_d = (env_q > `MEG_LVL_STEP) ?
                  env_q - `MEG_LVL_STEP : 16'h0000;        // RULE4
      end
      ST_REL: begin
        if (s_rel == 7'd0 || env_q <= `MEG_LVL_STEP) begin
          if (s_rel == 7'd0 || tick) begin
            env_d   = 16'h0000;                            // RULE7
            stage_d = ST_IDLE;
          end
        end else if (tick)
          env_d = env_q - `MEG_LVL_STEP;
      end
      default: begin
        stage_d = ST_IDLE;
      end
    endcase
    // note off, or pedal lift after a sustained note
    if ((NOTE_OFF && key_q) || ped_rel) begin
      if (NOTE_OFF && ped_held) begin
        sus_d = 1'b1;
        if (short_env && stage_q != ST_REL &&
            stage_q != ST_IDLE) begin
          stage_d = ST_REL;                                // RULE16
          cnt_d   = 34'd0;
        end else if (stage_q == ST_ATK) begin
          stage_d = ST_SUS;                                // RULE17
          env_d   = sus_lvl;
          cnt_d   = 34'd0;
        end else if (stage_q == ST_DLY && !freerun) begin
          stage_d = ST_IDLE;                               // RULE18
          env_d   = 16'h0000;
        end
        // completion case runs on and parks in sustain  // RULE19
      end else begin
        sus_d = 1'b0;
        if (stage_q == ST_DLY && hold) begin
          stage_d = ST_ATK;                                // RULE2
          cnt_d   = 34'd0;
          relp_d  = 1'b1;
        end else if (freerun) begin
          if (stage_q != ST_IDLE && stage_q != ST_REL)
            relp_d = 1'b1;                                 // RULE10
        end else if (stage_q != ST_IDLE &&
                     stage_q != ST_REL) begin
          stage_d = ST_REL;                                // RULE9
          cnt_d   = 34'd0;
        end
      end
    end
    // note on: start, restart or carry on
    if (NOTE_ON) begin
      sus_d = 1'b0;
      if (stage_q == ST_IDLE || (retrig && !legato) ||
          (legato && retrig)) begin                        // RULE11
        stage_d = first_st;
        cnt_d   = 34'd0;
        relp_d  = 1'b0;
        if (retrig)
          env_d = 16'h0000;
      end else if (!key_q && stage_q == ST_REL) begin
        stage_d = ST_ATK;                                  // RULE8
        cnt_d   = 34'd0;
        relp_d  = 1'b0;
      end
    end
  end

  // stage state and note bookkeeping
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      stage_q   <= ST_IDLE;
      env_q     <= 16'h0000;
      cnt_q     <= 34'd0;
      key_q     <= 1'b0;
      sus_q     <= 1'b0;
      relp_q    <= 1'b0;
      trk_key_q <= 7'd0;
      vel_q     <= 7'd0;
    end else begin
      stage_q <= stage_d;
      env_q   <= env_d;
      cnt_q   <= (stage_d != stage_q) ? 34'd0 : cnt_d;
      sus_q   <= sus_d;
      relp_q  <= relp_d;
      if (NOTE_ON) begin
        key_q     <= 1'b1;
        trk_key_q <= NOTE_KEY;
        vel_q     <= NOTE_VEL;
      end else if (NOTE_OFF)
        key_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // output scaling: level, velocity and filter gating
  // ---------------------------------------------------------------
  wire [16:0] lvl_p  = s_lvl * 10'd331;
  wire [10:0] lvl_f  = (s_lvl >= `MEG_SET_MAX) ? 11'd1024 :
                       lvl_p[15:5];                        // RULE21
  wire [6:0]  vdiff  = 7'd127 - vel_q;
  wire [13:0] vloss  = s_vmod * vdiff;
  wire [13:0] vgain  = 14'd12573 - vloss;                  // RULE22
  wire [26:0] vg_p   = vgain * 13'd5338;
  wire [10:0] vel_f  = (vg_p[26:16] > 11'd1024) ? 11'd1024
                                                 : vg_p[26:16];
  wire [26:0] o1     = env_q * lvl_f;
  wire [26:0] o2     = o1[25:10] * vel_f;
  // filter copy is silent without depth or a matrix route
  wire gate = ~mode_q[`MEG_MODE_FILT] | (s_dep != 7'd0) |
              mode_q[`MEG_MODE_MATSRC];                    // RULE23
  wire [15:0] out_d = gate ? ((o2[26]) ? `MEG_LVL_MAX : o2[25:10])
                           : 16'h0000;

  // registered outputs, one cycle behind the stage state
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ENV_OUT    <= 16'h0000;
      ENV_STAGE  <= ST_IDLE;
      ENV_ACTIVE <= 1'b0;
    end else begin
      ENV_OUT    <= out_d;
      ENV_STAGE  <= stage_q;
      ENV_ACTIVE <= (stage_q != ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  wire setup  = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE & PREADY;
  wire mapped = (PADDR == `MEG_OFS_TIME0) | (PADDR == `MEG_OFS_TIME1) |
                (PADDR == `MEG_OFS_MODE)  | (PADDR == `MEG_OFS_STAT);
  reg [31:0] rd_d;
  // read mux; status word shows live stage and level
  always @* begin
    case (PADDR)
      `MEG_OFS_TIME0: rd_d = time0_q;
      `MEG_OFS_TIME1: rd_d = time1_q;
      `MEG_OFS_MODE:  rd_d = mode_q;
      `MEG_OFS_STAT:  rd_d = {8'h00, env_q, 5'd0, stage_q};
      default:        rd_d = 32'h0000_0000;
    endcase
  end

  // answer prepared in setup so every access takes one cycle
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= (setup && !PWRITE) ? rd_d : 32'h0000_0000;
      PSLVERR <= setup & ~mapped;
    end
  end

  // register writes, only at the completing edge
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      time0_q <= `MEG_RST_TIME0;
      time1_q <= `MEG_RST_TIME1;
      mode_q  <= `MEG_RST_MODE;
    end else if (access && PWRITE) begin
      if (PADDR == `MEG_OFS_TIME0)
        time0_q <= PWDATA & 32'h7F7F_7F7F;
      if (PADDR == `MEG_OFS_TIME1)
        time1_q <= PWDATA & 32'h7F7F_7F7F;
      if (PADDR == `MEG_OFS_MODE)
        mode_q  <= PWDATA & 32'h0000_7F7F;
    end
  end

endmodule // meg_envelope

// ### verification/meg_env_props.sv
// Purpose: port assertions for the envelope generator
// Assumes: one clock domain, active-low reset
// Notes  : time settings are shadowed from apb writes
`include "meg_consts.vh"

module meg_env_props (
  // clock and reset
  input wire        CORE_CLK,
  input wire        RSTN,
  // apb
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [7:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  // notes
  input wire        NOTE_ON,
  input wire        NOTE_OFF,
  input wire        PEDAL,
  // envelope
  input wire [15:0] ENV_OUT,
  input wire [2:0]  ENV_STAGE
);
  timeunit 1ns;
  timeprecision 1ps;
  reg  [31:0] t0_q;
  reg  [31:0] t1_q;
  wire        wr_acc = PSEL && PENABLE && PREADY && PWRITE;
  wire        hold   = t0_q[6:0] > 7'h63;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  // shadow copy lands on the same edge as the device's own
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      t0_q <= `MEG_RST_TIME0;
      t1_q <= `MEG_RST_TIME1;
    end else if (wr_acc && PADDR == `MEG_OFS_TIME0) begin
      t0_q <= PWDATA;
    end else if (wr_acc && PADDR == `MEG_OFS_TIME1) begin
      t1_q <= PWDATA;
    end
  end

  AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  AST_READY_ACCESS: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  AST_ERR_UNMAPPED: assert property (PSEL && !PENABLE && PADDR > 8'h0C
    |=> PSLVERR) else $error("unmapped address accepted");
  AST_ZERO_DELAY: assert property (
    NOTE_ON && !$past(NOTE_ON) && ENV_STAGE == 3'h0
    && $past(ENV_STAGE) == 3'h0 && t0_q[6:0] == 7'h00
    |-> ##2 ENV_STAGE == 3'h2) else $error("attack not immediate");
  // pedal lift may act as a release, so it is excluded too
  AST_HOLD_WAIT: assert property (
    ENV_STAGE == 3'h1 && hold && $past(hold) && !$past(NOTE_ON)
    && !$past(NOTE_OFF) && $past(PEDAL) == $past(PEDAL, 2)
    |=> ENV_STAGE == 3'h1) else $error("hold delay left early");
  AST_SDEC_ZERO: assert property (
    ENV_STAGE == 3'h4 && $past(ENV_STAGE) != 3'h4 && t1_q[6:0] == 7'h00
    |-> ##[0:3] ENV_OUT == 16'h0000) else $error("no drop to zero");
  AST_SKIP_DECAY: assert property (
    ENV_STAGE == 3'h2 && t0_q[30:24] == 7'h63 |=> ENV_STAGE != 3'h3)
    else $error("decay not skipped");
  AST_LEVEL_ZERO: assert property (
    t1_q[22:16] == 7'h00 && $past(t1_q[22:16]) == 7'h00
    && $past(t1_q[22:16], 2) == 7'h00 |-> ENV_OUT == 16'h0000)
    else $error("output with level zero");
  AST_IDLE_ZERO: assert property (
    ENV_STAGE == 3'h0 && $past(ENV_STAGE) == 3'h0
    && $past(ENV_STAGE, 2) == 3'h0 |-> ENV_OUT == 16'h0000)
    else $error("output while idle");

  COV_HOLD_RUN: cover property (ENV_STAGE == 3'h1 ##1 ENV_STAGE == 3'h2);
  COV_RELEASE: cover property (ENV_STAGE == 3'h5);
  COV_ERR: cover property (PSLVERR);
endmodule // meg_env_props

bind meg_envelope meg_env_props u_props (
  .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .NOTE_ON(NOTE_ON), .NOTE_OFF(NOTE_OFF),
  .PEDAL(PEDAL), .ENV_OUT(ENV_OUT), .ENV_STAGE(ENV_STAGE));

// ### verification/meg_note_src.sv
// Purpose: note event source for the envelope generator
// Assumes: events launched just after a rising edge
// Notes  : key and velocity go stale once the strobe ends
module meg_note_src (
  // clock
  input  wire logic  clk,
  // note events
  output logic       note_on = 1'b0,
  output logic       note_off = 1'b0,
  output logic [6:0] note_key = 7'h00,
  output logic [6:0] note_vel = 7'h00,
  output logic       pedal = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // one-cycle note-on, key and velocity ride with it
  task automatic strike(input logic [6:0] k, input logic [6:0] v);
    @(posedge clk);
    note_on  <= 1'b1;
    note_key <= k;
    note_vel <= v;
    @(posedge clk);
    note_on  <= 1'b0;
    note_key <= ~k; // nothing promised after the strobe
    note_vel <= ~v;
  endtask

  // one-cycle note-off
  task automatic lift;
    @(posedge clk);
    note_off <= 1'b1;
    @(posedge clk);
    note_off <= 1'b0;
  endtask

  // pedal is a level, changed only after an edge
  task automatic set_pedal(input logic p);
    @(posedge clk);
    pedal <= p;
  endtask
endmodule // meg_note_src

// ### verification/test_multi_stage_envelope_generator.sv
// Purpose: self-checking bench for the envelope generator
// Assumes: delay and attack at zero or hold, short stages only
// Notes  : long time settings would take millions of cycles
`include "meg_consts.vh"

module test_multi_stage_envelope_generator;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK, RSTN = 1'b0;
  logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, rdat;
  logic        rerr;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, NOTE_ON, NOTE_OFF, PEDAL, ENV_ACTIVE;
  wire  [6:0]  NOTE_KEY, NOTE_VEL;
  wire  [15:0] ENV_OUT;
  wire  [2:0]  ENV_STAGE;
  int          fail_count = 0, samples_checked = 0;

  meg_envelope dut (
    .CORE_CLK(CORE_CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NOTE_ON(NOTE_ON),
    .NOTE_OFF(NOTE_OFF), .NOTE_KEY(NOTE_KEY), .NOTE_VEL(NOTE_VEL),
    .PEDAL(PEDAL), .ENV_OUT(ENV_OUT), .ENV_STAGE(ENV_STAGE),
    .ENV_ACTIVE(ENV_ACTIVE));
  meg_note_src src (.clk(CORE_CLK), .note_on(NOTE_ON),
    .note_off(NOTE_OFF), .note_key(NOTE_KEY), .note_vel(NOTE_VEL),
    .pedal(PEDAL));

  // 250 MHz core clock
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] want);
    samples_checked++;
    if (got !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; wait for ready is bounded, never assumed
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge CORE_CLK);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    check("pready", PREADY, 1'b1);
    if (PREADY !== 1'b1) final_report;
  endtask

  // sampled on falling edges so every update has landed
  task automatic wait_stage(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge CORE_CLK);
      n++;
    end while (ENV_STAGE !== s && n < lim);
    check("stage", ENV_STAGE, s);
    if (ENV_STAGE !== s) final_report;
  endtask

  // strike, read the sustain output, release to idle
  task automatic play(input logic [6:0] v, output logic [15:0] o);
    src.strike(7'h3C, v);
    repeat (2) @(negedge CORE_CLK);
    check("attack at once", ENV_STAGE, 3'h2);
    check("active", ENV_ACTIVE, 1'b1);
    wait_stage(3'h4, 20);
    repeat (3) @(negedge CORE_CLK);
    o = ENV_OUT;
    src.lift;
    wait_stage(3'h5, 10);
    wait_stage(3'h0, 40);
    check("inactive", ENV_ACTIVE, 1'b0);
  endtask

  task automatic t_regs;
    apb(1'b0, `MEG_OFS_TIME0, 32'h0000_0000);
    check("time0 reset", rdat, `MEG_RST_TIME0);
    apb(1'b0, `MEG_OFS_TIME1, 32'h0000_0000);
    check("time1 reset", rdat, `MEG_RST_TIME1);
    apb(1'b0, `MEG_OFS_MODE, 32'h0000_0000);
    check("mode reset", rdat, `MEG_RST_MODE);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    check("unmapped error", rerr, 1'b1);
    apb(1'b1, `MEG_OFS_STAT, 32'h0000_0007);
    apb(1'b0, `MEG_OFS_STAT, 32'h0000_0000);
    check("status read only", rdat, 32'h0000_0000);
    $display("register test done");
  endtask

  task automatic t_levels;
    logic [31:0] cfg [3] = '{32'h0063_0063, 32'h0000_0063, 32'h0063_0000};
    logic [15:0] want [3] = '{16'hFFFF, 16'h0000, 16'h0000};
    logic [15:0] o;
    logic [15:0] o2;
    logic [31:0] fm [3] = '{32'h0000_0020, 32'h0000_0120, 32'h0000_0060};
    logic [15:0] fw [3] = '{16'h0000, 16'hFFFF, 16'hFFFF};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `MEG_OFS_TIME1, cfg[i]);
      play(7'h7F, o);
      check("sustain output", o, want[i]);
    end
    apb(1'b1, `MEG_OFS_TIME1, 32'h6363_0063);
    play(7'h7F, o);
    play(7'h14, o2);
    check("soft below hard", o2 < o, 1'b1);
    apb(1'b1, `MEG_OFS_TIME1, `MEG_RST_TIME1);
    // filter copy: silent alone, live with depth or matrix route
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `MEG_OFS_MODE, fm[i]);
      play(7'h7F, o);
      check("filter gate", o, fw[i]);
    end
    apb(1'b1, `MEG_OFS_MODE, `MEG_RST_MODE);
    $display("level test done");
  endtask

  task automatic t_hold;
    apb(1'b1, `MEG_OFS_TIME0, 32'h6300_0064);
    src.strike(7'h3C, 7'h7F);
    repeat (30) @(negedge CORE_CLK);
    check("hold stage", ENV_STAGE, 3'h1);
    check("hold silent", ENV_OUT, 16'h0000);
    src.lift;
    wait_stage(3'h2, 10);
    wait_stage(3'h0, 40);
    apb(1'b1, `MEG_OFS_TIME0, `MEG_RST_TIME0);
    $display("hold test done");
  endtask

  // every trigger mode; only the restart bit may retrigger
  task automatic t_trig;
    logic seen;
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, `MEG_OFS_MODE, {27'd0, m[2], 2'b00, m[1:0]});
      src.strike(7'h3C, 7'h64);
      wait_stage(3'h4, 20);
      src.strike(7'h40, 7'h64);
      seen = 1'b0;
      repeat (6) begin
        @(negedge CORE_CLK);
        if (ENV_STAGE !== 3'h4) seen = 1'b1;
      end
      check("retrigger", seen, m[0]);
      src.lift;
      src.lift;
      wait_stage(3'h0, 40);
    end
    $display("trigger test done");
  endtask

  // decay length two octaves apart with tracking on
  task automatic t_track;
    int   d [2];
    logic ok;
    apb(1'b1, `MEG_OFS_MODE, 32'h0000_0004);
    apb(1'b1, `MEG_OFS_TIME0, 32'h6201_0000);
    for (int i = 0; i < 2; i++) begin
      src.strike(i ? 7'h54 : 7'h3C, 7'h7F);
      wait_stage(3'h3, 5);
      d[i] = 0;
      while (ENV_STAGE == 3'h3 && d[i] < 4000) begin
        @(negedge CORE_CLK);
        d[i]++;
      end
      wait_stage(3'h4, 5);
      src.lift;
      wait_stage(3'h0, 40);
    end
    ok = (d[0] + 8 > 2 * d[1]) && (d[0] < 2 * d[1] + 8);
    check("track halves", ok, 1'b1);
    apb(1'b1, `MEG_OFS_MODE, `MEG_RST_MODE);
    apb(1'b1, `MEG_OFS_TIME0, `MEG_RST_TIME0);
    $display("tracking test done");
  endtask

  task automatic pedal_case(input logic [31:0] md, input logic [31:0] t0,
                            input logic held);
    apb(1'b1, `MEG_OFS_MODE, md);
    apb(1'b1, `MEG_OFS_TIME0, t0);
    src.set_pedal(1'b1);
    src.strike(7'h3C, 7'h64);
    repeat (4) @(negedge CORE_CLK);
    src.lift;
    repeat (8) @(negedge CORE_CLK);
    check("pedal holds", ENV_STAGE inside {3'h3, 3'h4}, held);
    src.set_pedal(1'b0);
    wait_stage(3'h0, 40);
  endtask

  initial begin
    repeat (4) @(posedge CORE_CLK);
    RSTN <= 1'b1;
    t_regs;
    t_levels;
    t_hold;
    t_trig;
    t_track;
    pedal_case(32'h0000_0000, 32'h6300_0000, 1'b0);
    pedal_case(32'h0000_0008, 32'h6201_0000, 1'b1);
    pedal_case(32'h0000_0008, 32'h6300_0000, 1'b0);
    $display("pedal test done");
    final_report;
  end
endmodule // test_multi_stage_envelope_generator
